// ==== rtl/bdio_pkg.sv ====
/*
  Constants for the sixteen-channel bidirectional digital I/O block:
  widths, filter timing, register map, field positions, reset values.
  Assumes a single 125 MHz clock domain and an APB register bus.
*/
`default_nettype none

package bdio_pkg;

  // Channel and group geometry
  localparam int unsigned CHAN_N  = 16;
  localparam int unsigned GRP_N   = 2;
  localparam int unsigned GRP_W   = 8;
  localparam int unsigned CNT_W   = 19;

  // Filter timing
  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned FILT_SLOW_US  = 3000;
  localparam int unsigned FILT_FAST_US  = 10;
  localparam int unsigned FILT_SLOW_CYC = FILT_SLOW_US * CLK_MHZ;
  localparam int unsigned FILT_FAST_CYC = FILT_FAST_US * CLK_MHZ;

  // Register map, byte addresses
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_OUT_IMG = 8'h04;
  localparam logic [7:0] ADDR_IN_IMG  = 8'h08;
  localparam logic [7:0] ADDR_STAT    = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h14;

  // Field positions
  localparam int unsigned CTRL_DC_BIT   = 0;
  localparam int unsigned GRP_SYNC_BIT  = 8;
  localparam int unsigned GRP_INV_BIT   = 9;
  localparam int unsigned GRP_TOG_BIT   = 10;
  localparam int unsigned IN_G1_BASE    = 16;
  localparam int unsigned STAT_OVL_BIT  = 0;
  localparam int unsigned STAT_ARM_BIT  = 1;
  localparam int unsigned IRQ_SYNC_BIT  = 0;
  localparam int unsigned IRQ_INV0_BIT  = 1;
  localparam int unsigned IRQ_INV1_BIT  = 2;
  localparam int unsigned IRQ_OVL_BIT   = 3;
  localparam int unsigned IRQ_UPD_BIT   = 4;
  localparam int unsigned IRQ_W         = 5;

  // Reset values
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
  localparam logic [15:0] OUT_IMG_RST  = 16'h0000;
  localparam logic [4:0]  IRQ_MSK_RST  = 5'h00;

endpackage : bdio_pkg

`default_nettype wire

// ==== rtl/bdio_top.sv ====
/*
  Sixteen-channel bidirectional digital I/O with cyclic process image.
  Holds pin synchronisers, per-channel input filters, the input image
  latched once per bus cycle, output drive, LEDs, interrupts, APB slave.
  Assumes cycle_tick_i, sync_err_i and read_err_i come from same-clock
  logic of the fieldbus slave; pins and overload sense are asynchronous.
*/
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Sync flag only meaningful in synchronised-clock mode
// - Sync flag reports error in last bus cycle
// - Invalid flag set when group read failed
// - Toggle bit inverts on each group update
// - Two output groups drive physical outputs
// - Sixteen channels, no direction configuration
// - Driven output reads back in input image
// - Input filter 3.0 ms slow, 10 us fast
// - Sensor supply overload lights red LED
// - One LED per channel shows its state
// - Group: eight inputs then three flags
module bdio_top #(
  parameter int unsigned SLOW_CYC     = bdio_pkg::FILT_SLOW_CYC,
  parameter bit          FAST_VARIANT = 1'b0
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        cycle_tick_i,
  input  wire logic        sync_err_i,
  input  wire logic [1:0]  read_err_i,
  input  wire logic [15:0] chan_pin_i,
  input  wire logic        sensor_ovl_i,
  output logic      [15:0] chan_drive_o,
  output logic      [15:0] chan_led_o,
  output logic             supply_led_o,
  output logic             irq_o
);

  localparam int unsigned CW    = bdio_pkg::CNT_W;
  localparam int unsigned LIM_I = FAST_VARIANT ? bdio_pkg::FILT_FAST_CYC : SLOW_CYC;
  // Last count before a new level is accepted
  localparam logic [CW-1:0] LIM_M1 = CW'(LIM_I - 1);

  logic [15:0]   pin_s1_reg;      // First sync stage
  logic [15:0]   pin_s2_reg;      // Second sync stage
  logic          ovl_s1_reg;      // Overload first stage
  logic          ovl_s2_reg;      // Overload second stage
  logic          ovl_prev_reg;    // For rising edge
  logic [15:0]   raw_w;           // Sensed level per channel
  logic [15:0]   stable_reg;      // Filtered level per channel
  logic          dc_mode_reg;     // Synchronised-clock mode
  logic [15:0]   out_img_reg;     // Output image from master
  logic          armed_reg;       // First image received
  logic [15:0]   drive_reg;       // Output drivers
  logic          sync_seen_reg;   // Sync error this cycle
  logic          seen_now_w;      // Including this cycle
  logic [7:0]    img_data_reg [2];// Latched input groups
  logic [1:0]    sync_flag_reg;   // Per-group sync flag
  logic [1:0]    inv_reg;         // Per-group invalid flag
  logic [1:0]    tog_reg;         // Per-group update toggle
  logic [4:0]    irq_st_reg;      // Sticky event bits
  logic [4:0]    irq_msk_reg;     // Interrupt mask
  logic [4:0]    irq_ev_w;        // Events this cycle
  logic [31:0]   prdata_reg;      // Read data, setup phase
  logic          perr_reg;        // Unmapped, setup phase
  logic          led_reg;         // Red supply indicator
  logic          mapped_w;        // Address decodes
  logic          setup_w;         // APB setup phase
  logic          wr_w;            // APB write completes
  logic          rd_irq_w;        // Status read completes
  logic [31:0]   rd_mux_w;        // Read mux
  logic [10:0]   grp_w [2];       // Group as seen by master

  // Two-stage pin synchronisers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_reg <= 16'h0000;
      pin_s2_reg <= 16'h0000;
      ovl_s1_reg <= 1'b0;
      ovl_s2_reg <= 1'b0;
    end else begin
      pin_s1_reg <= chan_pin_i;
      pin_s2_reg <= pin_s1_reg;
      ovl_s1_reg <= sensor_ovl_i;
      ovl_s2_reg <= ovl_s1_reg;
    end
  end

  // Sampler sees its own driver as well as the pin
  assign raw_w = pin_s2_reg | drive_reg;

  // Per-channel debounce: level must hold LIM_I cycles
  // Pulses shorter than the filter never reach the image
  for (genvar ch = 0; ch < bdio_pkg::CHAN_N; ch++) begin : g_filt
    logic [CW-1:0] cnt_reg; // Cycles the new level held
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
        cnt_reg        <= '0;
        stable_reg[ch] <= 1'b0;
      end else if (raw_w[ch] == stable_reg[ch]) begin
        // Bounce back restarts the wait
        cnt_reg <= '0;
      end else if (cnt_reg == LIM_M1) begin
        stable_reg[ch] <= raw_w[ch];
        cnt_reg        <= '0;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  // Sync errors gathered over the running bus cycle
  // An error in the tick cycle still counts for that cycle
  assign seen_now_w = sync_seen_reg | sync_err_i;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_seen_reg <= 1'b0;
    end else if (cycle_tick_i) begin
      sync_seen_reg <= 1'b0;
    end else if (sync_err_i) begin
      sync_seen_reg <= 1'b1;
    end
  end

  // Input image latched once per bus cycle
  for (genvar g = 0; g < bdio_pkg::GRP_N; g++) begin : g_grp
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
        img_data_reg[g]  <= 8'h00;
        sync_flag_reg[g] <= 1'b0;
        inv_reg[g]       <= 1'b0;
        tog_reg[g]       <= 1'b0;
      end else if (cycle_tick_i) begin
        // Flag only driven in synchronised mode
        sync_flag_reg[g] <= dc_mode_reg & seen_now_w;
        inv_reg[g]       <= read_err_i[g];
        if (!read_err_i[g]) begin
          // Fresh sample: store and invert toggle
          img_data_reg[g] <= stable_reg[g*bdio_pkg::GRP_W +: bdio_pkg::GRP_W];
          tog_reg[g]      <= ~tog_reg[g];
        end
      end
    end
    // Eight inputs then sync, invalid, toggle
    assign grp_w[g] = {tog_reg[g], inv_reg[g], sync_flag_reg[g], img_data_reg[g]};
  end

  // Outputs held off until the master arms them
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_reg <= 16'h0000;
    end else if (armed_reg) begin
      drive_reg <= out_img_reg;
    end else begin
      drive_reg <= 16'h0000;
    end
  end

  assign chan_drive_o = drive_reg;

  // LEDs: channel state and supply overload
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      led_reg      <= 1'b0;
      ovl_prev_reg <= 1'b0;
    end else begin
      led_reg      <= ovl_s2_reg;
      ovl_prev_reg <= ovl_s2_reg;
    end
  end

  assign chan_led_o   = stable_reg;
  assign supply_led_o = led_reg;

  // APB decode
  assign setup_w  = psel_i & ~penable_i;
  assign mapped_w = (paddr_i == bdio_pkg::ADDR_CTRL) | (paddr_i == bdio_pkg::ADDR_OUT_IMG) |
                    (paddr_i == bdio_pkg::ADDR_IN_IMG) | (paddr_i == bdio_pkg::ADDR_STAT) |
                    (paddr_i == bdio_pkg::ADDR_IRQ_ST) | (paddr_i == bdio_pkg::ADDR_IRQ_MSK);
  assign wr_w     = psel_i & penable_i & pwrite_i & ~perr_reg;
  assign rd_irq_w = psel_i & penable_i & ~pwrite_i & (paddr_i == bdio_pkg::ADDR_IRQ_ST);

  // Read mux, sampled in the setup phase
  always_comb begin
    rd_mux_w = bdio_pkg::ZERO_WORD;
    unique case (paddr_i)
      bdio_pkg::ADDR_CTRL: begin
        rd_mux_w[bdio_pkg::CTRL_DC_BIT] = dc_mode_reg;
      end
      bdio_pkg::ADDR_OUT_IMG: begin
        rd_mux_w[15:0] = out_img_reg;
      end
      bdio_pkg::ADDR_IN_IMG: begin
        rd_mux_w[10:0] = grp_w[0];
        rd_mux_w[bdio_pkg::IN_G1_BASE +: 11] = grp_w[1];
      end
      bdio_pkg::ADDR_STAT: begin
        rd_mux_w[bdio_pkg::STAT_OVL_BIT] = ovl_s2_reg;
        rd_mux_w[bdio_pkg::STAT_ARM_BIT] = armed_reg;
      end
      bdio_pkg::ADDR_IRQ_ST: begin
        rd_mux_w[4:0] = irq_st_reg;
      end
      bdio_pkg::ADDR_IRQ_MSK: begin
        rd_mux_w[4:0] = irq_msk_reg;
      end
      default: begin
        rd_mux_w = bdio_pkg::ZERO_WORD;
      end
    endcase
  end

  // Read data and error captured at setup
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_reg <= bdio_pkg::ZERO_WORD;
      perr_reg   <= 1'b0;
    end else if (setup_w) begin
      prdata_reg <= pwrite_i ? bdio_pkg::ZERO_WORD : rd_mux_w;
      perr_reg   <= ~mapped_w;
    end
  end

  assign prdata_o  = prdata_reg;
  assign pslverr_o = perr_reg;
  // No wait states: each access ends after one cycle
  assign pready_o  = 1'b1;

  // Software-written registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dc_mode_reg <= 1'b0;
      out_img_reg <= bdio_pkg::OUT_IMG_RST;
      armed_reg   <= 1'b0;
      irq_msk_reg <= bdio_pkg::IRQ_MSK_RST;
    end else if (wr_w) begin
      if (paddr_i == bdio_pkg::ADDR_CTRL) begin
        dc_mode_reg <= pwdata_i[bdio_pkg::CTRL_DC_BIT];
      end
      if (paddr_i == bdio_pkg::ADDR_OUT_IMG) begin
        out_img_reg <= pwdata_i[15:0];
        armed_reg   <= 1'b1;
      end
      if (paddr_i == bdio_pkg::ADDR_IRQ_MSK) begin
        irq_msk_reg <= pwdata_i[4:0];
      end
    end
  end

  // Events feeding the sticky status
  always_comb begin
    irq_ev_w = '0;
    irq_ev_w[bdio_pkg::IRQ_SYNC_BIT] = cycle_tick_i & dc_mode_reg & seen_now_w;
    irq_ev_w[bdio_pkg::IRQ_INV0_BIT] = cycle_tick_i & read_err_i[0];
    irq_ev_w[bdio_pkg::IRQ_INV1_BIT] = cycle_tick_i & read_err_i[1];
    irq_ev_w[bdio_pkg::IRQ_OVL_BIT]  = ovl_s2_reg & ~ovl_prev_reg;
    irq_ev_w[bdio_pkg::IRQ_UPD_BIT]  = cycle_tick_i;
  end

  // Read clears only bits reported; new event wins
  // Clear and event in one cycle: the event stays set
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_st_reg <= '0;
    end else if (rd_irq_w) begin
      irq_st_reg <= (irq_st_reg & ~prdata_reg[4:0]) | irq_ev_w;
    end else begin
      irq_st_reg <= irq_st_reg | irq_ev_w;
    end
  end

  assign irq_o = |(irq_st_reg & irq_msk_reg);

  // Checks on the block clock, all idle during reset
  // Partner inputs share the clock, so no settling slack
  sync_gate_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cycle_tick_i && !dc_mode_reg) |=> (sync_flag_reg == 2'b00))
    else $error("sync flag set outside synchronised mode");

  sync_set_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cycle_tick_i && dc_mode_reg && sync_err_i) |=> (sync_flag_reg == 2'b11))
    else $error("sync error not reported");

  inv_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cycle_tick_i |=> (inv_reg == $past(read_err_i)))
    else $error("invalid flag does not follow read error");

  toggle_flip_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cycle_tick_i && !read_err_i[0]) |=> (tog_reg[0] != $past(tog_reg[0])))
    else $error("toggle did not invert on update");

  // Drivers follow the image one edge after it is seen
  drive_map_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    armed_reg |=> (chan_drive_o == $past(out_img_reg)))
    else $error("output drive differs from image");

  readback_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (($past(stable_reg) & ~stable_reg & $past(drive_reg)) == 16'h0000))
    else $error("driven output filtered low");

  filt_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(stable_reg[0]) |-> $past(raw_w[0]))
    else $error("filter accepted level not present");

  ovl_led_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ovl_s2_reg |=> supply_led_o)
    else $error("overload not shown on LED");

  upd_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !cycle_tick_i |=> ($stable(tog_reg) && $stable(inv_reg)))
    else $error("image changed without bus cycle");

  out_off_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !armed_reg |-> (chan_drive_o == 16'h0000))
    else $error("output driven before first image");

  sync_clr_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cycle_tick_i && !seen_now_w) |=> (sync_flag_reg == 2'b00))
    else $error("sync flag set without error");

  toggle_held_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cycle_tick_i && read_err_i[0]) |=> ($stable(tog_reg[0]) && $stable(img_data_reg[0])))
    else $error("failed group updated its image");

  led_off_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !ovl_s2_reg |=> !supply_led_o)
    else $error("supply LED lit without overload");

  img_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !cycle_tick_i |=> ($stable(img_data_reg[0]) && $stable(img_data_reg[1])))
    else $error("input data changed without bus cycle");

endmodule : bdio_top

`default_nettype wire

// ==== bench/bdio_master_model.sv ====
/*
  Fieldbus master model: bus cycle ticks, sync and read error lines.
  Assumes the bench clock and an active-high asynchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none
module bdio_master_model #(
  parameter int unsigned PER = 16
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       sync_bad_i,
  input  wire logic [1:0] rd_bad_i,
  output logic            tick_o,
  output logic            sync_err_o,
  output logic      [1:0] read_err_o
);
  logic [7:0] cnt_reg;  // Position in bus cycle

  // One tick per bus cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 8'h00;
      tick_o  <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg == 8'(PER - 1)) ? 8'h00 : cnt_reg + 8'h01;
      tick_o  <= (cnt_reg == 8'(PER - 1));
    end
  end

  // Errors only when the bench commands them
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_err_o <= 1'b0;
      read_err_o <= 2'b00;
    end else begin
      sync_err_o <= sync_bad_i;
      read_err_o <= rd_bad_i;
    end
  end
endmodule : bdio_master_model
`default_nettype wire

// ==== bench/bdio_top_test.sv ====
/*
  Self-checking bench for the digital I/O block.
  Assumes bdio_pkg, bdio_top and the master model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module bdio_top_test;
  localparam int unsigned LIM = 20;  // Shortened filter count
  logic        clk, rst, psel, pen, pwr, pready, pslverr, err;
  logic        tick, serr, sbad, ovl, sled, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, a, seed;
  logic [1:0]  rerr, rbad;
  logic [15:0] pins, drive, led, d, p;
  int          fail_count, cmp_count;

  bdio_top #(.SLOW_CYC(LIM), .FAST_VARIANT(1'b0)) bdio_top_i (
    .ref_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .cycle_tick_i(tick),
    .sync_err_i(serr), .read_err_i(rerr), .chan_pin_i(pins),
    .sensor_ovl_i(ovl), .chan_drive_o(drive), .chan_led_o(led),
    .supply_led_o(sled), .irq_o(irq));

  bdio_master_model #(.PER(16)) bdio_master_model_i (
    .clk_i(clk), .rst_i(rst), .sync_bad_i(sbad), .rd_bad_i(rbad),
    .tick_o(tick), .sync_err_o(serr), .read_err_o(rerr));

  // Free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Verdict and end of run
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  // Compare seen against expected
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Input bits of both groups as placed in the image
  function automatic logic [31:0] exp_img(input logic [15:0] v);
    exp_img = {8'h00, v[15:8], 8'h00, v[7:0]};
  endfunction : exp_img

  // One APB transfer, bounded wait on pready
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= ad;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail_count++;
      report_and_stop;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  // Wait for the edge that takes a cycle tick
  task automatic wait_tick;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1 && n < 64);
    if (tick !== 1'b1) begin
      fail_count++;
      report_and_stop;
    end
  endtask : wait_tick

  // Main sequence
  initial begin
    fail_count = 0;
    cmp_count  = 0;
    seed = 32'h0000_0043;
    rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00;
    pwdata = 32'h0000_0000; pins = 16'h0000; ovl = 1'b0; sbad = 1'b0; rbad = 2'b00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Reset values, unmapped access refused
    apb(1'b0, bdio_pkg::ADDR_OUT_IMG, bdio_pkg::ZERO_WORD, rd, err);
    chk("out_img rst", rd, bdio_pkg::ZERO_WORD);
    chk("slverr ok", {31'h0, err}, 32'h0000_0000);
    apb(1'b0, 8'h20, bdio_pkg::ZERO_WORD, rd, err);
    chk("slverr", {31'h0, err}, 32'h0000_0001);
    chk("unmapped rd", rd, bdio_pkg::ZERO_WORD);
    $display("reset test done");
    // Filter delay, LEDs, outputs still off
    seed = lfsr(seed);
    p = seed[15:0] | 16'h0001;
    pins <= p;
    repeat (LIM / 2) @(posedge clk);
    #1 chk("led early", {16'h0, led}, bdio_pkg::ZERO_WORD);
    repeat (LIM + 4) @(posedge clk);
    #1 chk("led", {16'h0, led}, {16'h0, p});
    chk("drive off", {16'h0, drive}, bdio_pkg::ZERO_WORD);
    wait_tick;
    apb(1'b0, bdio_pkg::ADDR_IN_IMG, bdio_pkg::ZERO_WORD, rd, err);
    chk("img pins", rd & 32'h00FF_00FF, exp_img(p));
    $display("filter test done");
    // Output drive and read back
    seed = lfsr(seed);
    d = seed[31:16] ^ seed[15:0];
    apb(1'b1, bdio_pkg::ADDR_OUT_IMG, {16'h0, d}, rd, err);
    pins <= 16'h0000;
    repeat (2) @(posedge clk);
    #1 chk("drive", {16'h0, drive}, {16'h0, d});
    repeat (LIM + 8) @(posedge clk);
    #1 chk("led back", {16'h0, led}, {16'h0, d});
    wait_tick;
    apb(1'b0, bdio_pkg::ADDR_IN_IMG, bdio_pkg::ZERO_WORD, rd, err);
    chk("img back", rd & 32'h00FF_00FF, exp_img(d));
    $display("output test done");
    // Toggle on each update, held by a failed group
    apb(1'b0, bdio_pkg::ADDR_IN_IMG, bdio_pkg::ZERO_WORD, a, err);
    wait_tick;
    apb(1'b0, bdio_pkg::ADDR_IN_IMG, bdio_pkg::ZERO_WORD, rd, err);
    chk("tog g0", {31'h0, rd[10]}, {31'h0, ~a[10]});
    chk("tog g1", {31'h0, rd[26]}, {31'h0, ~a[26]});
    chk("valid", {30'h0, rd[25], rd[9]}, 32'h0000_0000);
    rbad <= 2'b01;
    wait_tick;
    apb(1'b0, bdio_pkg::ADDR_IN_IMG, bdio_pkg::ZERO_WORD, a, err);
    wait_tick;
    apb(1'b0, bdio_pkg::ADDR_IN_IMG, bdio_pkg::ZERO_WORD, rd, err);
    chk("invalid", {30'h0, rd[25], rd[9]}, 32'h0000_0001);
    chk("tog held", {31'h0, rd[10]}, {31'h0, a[10]});
    chk("tog g1 err", {31'h0, rd[26]}, {31'h0, ~a[26]});
    rbad <= 2'b00;
    $display("toggle test done");
    // Sync flag ignored outside sync mode, then reported
    sbad <= 1'b1;
    repeat (2) wait_tick;
    apb(1'b0, bdio_pkg::ADDR_IN_IMG, bdio_pkg::ZERO_WORD, rd, err);
    chk("sync off", {30'h0, rd[24], rd[8]}, 32'h0000_0000);
    apb(1'b1, bdio_pkg::ADDR_CTRL, 32'h0000_0001, rd, err);
    repeat (2) wait_tick;
    apb(1'b0, bdio_pkg::ADDR_IN_IMG, bdio_pkg::ZERO_WORD, rd, err);
    chk("sync err", {30'h0, rd[24], rd[8]}, 32'h0000_0003);
    sbad <= 1'b0;
    repeat (3) wait_tick;
    apb(1'b0, bdio_pkg::ADDR_IN_IMG, bdio_pkg::ZERO_WORD, rd, err);
    chk("sync clr", {30'h0, rd[24], rd[8]}, 32'h0000_0000);
    $display("sync test done");
    // Overload LED and masked interrupt
    apb(1'b1, bdio_pkg::ADDR_IRQ_MSK, 32'h0000_0001 << bdio_pkg::IRQ_OVL_BIT, rd, err);
    ovl <= 1'b1;
    #1 chk("irq idle", {31'h0, irq}, 32'h0000_0000);
    repeat (2) @(posedge clk);
    #1 chk("led slow", {31'h0, sled}, 32'h0000_0000);
    @(posedge clk);
    #1 chk("supply led", {31'h0, sled}, 32'h0000_0001);
    chk("irq on", {31'h0, irq}, 32'h0000_0001);
    apb(1'b0, bdio_pkg::ADDR_STAT, bdio_pkg::ZERO_WORD, rd, err);
    chk("stat ovl", {31'h0, rd[0]}, 32'h0000_0001);
    apb(1'b0, bdio_pkg::ADDR_IRQ_ST, bdio_pkg::ZERO_WORD, rd, err);
    chk("irq st", {31'h0, rd[3]}, 32'h0000_0001);
    @(posedge clk);
    ovl <= 1'b0;
    #1 chk("irq clr", {31'h0, irq}, 32'h0000_0000);
    $display("overload test done");
    // Mid-run reset: drivers off again until a new image
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("drive in rst", {16'h0, drive}, bdio_pkg::ZERO_WORD);
    @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, bdio_pkg::ADDR_STAT, bdio_pkg::ZERO_WORD, rd, err);
    chk("armed rst", {31'h0, rd[bdio_pkg::STAT_ARM_BIT]}, 32'h0000_0000);
    chk("drive after rst", {16'h0, drive}, bdio_pkg::ZERO_WORD);
    $display("reset again test done");
    report_and_stop;
  end
endmodule : bdio_top_test
`default_nettype wire
